// *** common/pim_pkg.sv ***
/*
  Constants for the transceiver interrupt, special status and extended access registers.
  Assumes a 16-bit management register port with 5-bit register indices.
*/
package pim_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices on the management port
  localparam logic [4:0]  REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0]  REG_MMD_DATA = 5'h0E;
  localparam logic [4:0]  REG_IRQ_SRC  = 5'h1D;
  localparam logic [4:0]  REG_IRQ_MASK = 5'h1E;
  localparam logic [4:0]  REG_SPECIAL  = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flag positions
  localparam int FLAG_LO          = 1;
  localparam int FLAG_HI          = 8;
  localparam int FLAG_WAKE        = 8;
  localparam int FLAG_ENERGY      = 7;
  localparam int FLAG_ANEG_DONE   = 6;
  localparam int FLAG_REMOTE_FLT  = 5;
  localparam int FLAG_LINK_DOWN   = 4;
  localparam int FLAG_PARTNER_ACK = 3;
  localparam int FLAG_PAR_DET_FLT = 2;
  localparam int FLAG_PAGE_RX     = 1;
  localparam logic [8:1] FLAGS_RESET = 8'h00;
  localparam logic [8:1] MASK_RESET  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Special control/status fields
  localparam int         SPC_ANEG_DONE = 12;
  localparam int         SPC_CODER_EN  = 6;
  localparam int         SPC_SPEED_LO  = 2;
  localparam int         SPC_SPEED_HI  = 4;
  localparam logic       CODER_RESET   = 1'b1;
  localparam logic [2:0] SPD_10_HALF   = 3'h1;
  localparam logic [2:0] SPD_10_FULL   = 3'h5;
  localparam logic [2:0] SPD_100_HALF  = 3'h2;
  localparam logic [2:0] SPD_100_FULL  = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // Extended access control fields
  localparam int         MMD_FN_HI  = 15;
  localparam int         MMD_FN_LO  = 14;
  localparam int         MMD_DEV_HI = 4;
  localparam int         MMD_DEV_LO = 0;
  localparam logic [4:0] DEV_PCS    = 5'h03;
  localparam logic [4:0] DEV_ANEG   = 5'h07;
  localparam logic [4:0] DEV_VENDOR = 5'h1E;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PIM_FN_ADDR   = 2'h0,
    PIM_FN_DATA   = 2'h1,
    PIM_FN_DATA_2 = 2'h2,
    PIM_FN_DATA_3 = 2'h3
  } pim_fn_type;

endpackage

// *** rtl/pim_regs.sv ***
/*
  Interrupt source flags, interrupt mask, special control/status and the indirect
  extended register window of the transceiver management block.
  Assumes the serial management engine delivers one-cycle read and write strobes
  with a register index, and that the extended register storage answers its read
  data combinationally from the selected device and address.
*/
`timescale 1ns/1ps

// How it works
// [R1] Wake event sets flag 8 and it stays latched high.
// [R2] Rising line energy indication latches flag 7.
// [R3] Auto-negotiation completing latches flag 6.
// [R4] Remote fault from the partner latches flag 5.
// [R5] Link status falling latches flag 4.
// [R6] Partner acknowledge received latches flag 3.
// [R7] Parallel detection fault latches flag 2.
// [R8] Page received latches flag 1; bits 15:9 and 0 read zero.
// [R9] Reading the source register clears flags unless their event recurs; reset clears.
// [R10] Mask bits 8:1 enable same-numbered flags; reset zero; others read zero.
// [R11] Interrupt output high while any enabled flag is set.
// [R12] Status bit 12 shows auto-negotiation done.
// [R13] Status bit 6 enables symbol coder, resets 1; zero accepted only in MII mode.
// [R14] Status bits 4:2 show resolved speed and duplex code.
// [R15] Extended registers are reached only through control and address/data registers.
// [R16] Extended devices 3, 7 and 30 are supported; others read zero.
// [R17] Manager first writes control with address function and device number.
// [R18] Manager then writes the 16-bit extended register address.
// [R19] Manager then writes control with data function, same device.
// [R20] Data register reads or writes the selected extended register.
module pim_regs (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // Management register port
  input  wire logic [4:0]  i_mgmt_addr,
  input  wire logic        i_mgmt_wr,
  input  wire logic        i_mgmt_rd,
  input  wire logic [15:0] i_mgmt_wdata,
  output logic      [15:0] o_mgmt_rdata,
  output logic             o_mgmt_rvalid,
  // Event and status inputs
  input  wire logic        i_wake_event,
  input  wire logic        i_line_energy_detected,
  input  wire logic        i_autoneg_done,
  input  wire logic        i_remote_fault,
  input  wire logic        i_link_up,
  input  wire logic        i_partner_ack,
  input  wire logic        i_parallel_detect_fault,
  input  wire logic        i_page_received,
  input  wire logic [2:0]  i_resolved_speed_duplex,
  input  wire logic        i_mii_mode,
  // Control and interrupt outputs
  output logic             o_coder_enable,
  output logic             o_irq,
  // Extended register storage
  output logic      [4:0]  o_ext_device_number,
  output logic      [15:0] o_ext_addr,
  output logic             o_ext_wr,
  output logic      [15:0] o_ext_wdata,
  input  wire logic [15:0] i_ext_rdata
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [8:1]  flags_q;
  logic [8:1]  flags_d;
  logic [8:1]  mask_q;
  logic [8:1]  events;
  logic        energy_prev_q;
  logic        aneg_prev_q;
  logic        link_prev_q;
  logic        coder_q;
  logic [15:0] mmd_ctrl_q;
  logic [15:0] mmd_addr_q;
  logic [15:0] rdata_d;
  logic        src_read;
  pim_pkg::pim_fn_type mmd_fn;

  function automatic logic dev_supported(input logic [4:0] dev);
    dev_supported = (dev == pim_pkg::DEV_PCS) || (dev == pim_pkg::DEV_ANEG) ||
                    (dev == pim_pkg::DEV_VENDOR);
  endfunction

  function automatic logic hit(input logic [4:0] idx, input logic strobe,
                               input logic [4:0] addr);
    hit = strobe && (addr == idx);
  endfunction

  assign mmd_fn   = pim_pkg::pim_fn_type'(mmd_ctrl_q[pim_pkg::MMD_FN_HI:pim_pkg::MMD_FN_LO]);
  assign src_read = hit(pim_pkg::REG_IRQ_SRC, i_mgmt_rd, i_mgmt_addr);

  ////////////////////////////////////////////////////////////////////////////////
  // Event detection
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      energy_prev_q <= 1'b0;
      aneg_prev_q   <= 1'b0;
      link_prev_q   <= 1'b0;
    end else begin
      energy_prev_q <= i_line_energy_detected;
      aneg_prev_q   <= i_autoneg_done;
      link_prev_q   <= i_link_up;
    end
  end

  always_comb begin
    events                           = '0;
    events[pim_pkg::FLAG_WAKE]        = i_wake_event;                             // R1
    events[pim_pkg::FLAG_ENERGY]      = i_line_energy_detected && !energy_prev_q; // R2
    events[pim_pkg::FLAG_ANEG_DONE]   = i_autoneg_done && !aneg_prev_q;           // R3
    events[pim_pkg::FLAG_REMOTE_FLT]  = i_remote_fault;                           // R4
    events[pim_pkg::FLAG_LINK_DOWN]   = !i_link_up && link_prev_q;                // R5
    events[pim_pkg::FLAG_PARTNER_ACK] = i_partner_ack;                            // R6
    events[pim_pkg::FLAG_PAR_DET_FLT] = i_parallel_detect_fault;                  // R7
    events[pim_pkg::FLAG_PAGE_RX]     = i_page_received;                          // R8
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latching flags, set wins over the read clear
  assign flags_d = events | (flags_q & {8{!src_read}}); // R9

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_q <= pim_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mask and interrupt output
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_q <= pim_pkg::MASK_RESET;
    end else if (hit(pim_pkg::REG_IRQ_MASK, i_mgmt_wr, i_mgmt_addr)) begin
      mask_q <= i_mgmt_wdata[pim_pkg::FLAG_HI:pim_pkg::FLAG_LO]; // R10
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flags_q & mask_q); // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Symbol coder control
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      coder_q <= pim_pkg::CODER_RESET;
    end else if (hit(pim_pkg::REG_SPECIAL, i_mgmt_wr, i_mgmt_addr)) begin
      // Bypass is refused unless the MAC side runs MII
      if (i_mgmt_wdata[pim_pkg::SPC_CODER_EN] || i_mii_mode) begin
        coder_q <= i_mgmt_wdata[pim_pkg::SPC_CODER_EN]; // R13
      end
    end
  end

  assign o_coder_enable = coder_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Extended access window
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mmd_ctrl_q <= pim_pkg::WORD_ZERO;
    end else if (hit(pim_pkg::REG_MMD_CTRL, i_mgmt_wr, i_mgmt_addr)) begin
      mmd_ctrl_q <= i_mgmt_wdata; // R17 R19
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mmd_addr_q <= pim_pkg::WORD_ZERO;
    end else if (hit(pim_pkg::REG_MMD_DATA, i_mgmt_wr, i_mgmt_addr) &&
                 mmd_fn == pim_pkg::PIM_FN_ADDR) begin
      mmd_addr_q <= i_mgmt_wdata; // R18
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ext_wr    <= 1'b0;
      o_ext_wdata <= pim_pkg::WORD_ZERO;
    end else begin
      o_ext_wr <= hit(pim_pkg::REG_MMD_DATA, i_mgmt_wr, i_mgmt_addr) &&
                  mmd_fn != pim_pkg::PIM_FN_ADDR &&
                  dev_supported(mmd_ctrl_q[pim_pkg::MMD_DEV_HI:pim_pkg::MMD_DEV_LO]); // R16 R20
      if (hit(pim_pkg::REG_MMD_DATA, i_mgmt_wr, i_mgmt_addr)) begin
        o_ext_wdata <= i_mgmt_wdata; // R20
      end
    end
  end

  assign o_ext_device_number = mmd_ctrl_q[pim_pkg::MMD_DEV_HI:pim_pkg::MMD_DEV_LO]; // R15
  assign o_ext_addr          = mmd_addr_q; // R15

  ////////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    rdata_d = pim_pkg::WORD_ZERO;
    case (i_mgmt_addr)
      pim_pkg::REG_IRQ_SRC: begin
        rdata_d[pim_pkg::FLAG_HI:pim_pkg::FLAG_LO] = flags_q; // R8
      end
      pim_pkg::REG_IRQ_MASK: begin
        rdata_d[pim_pkg::FLAG_HI:pim_pkg::FLAG_LO] = mask_q; // R10
      end
      pim_pkg::REG_SPECIAL: begin
        rdata_d[pim_pkg::SPC_ANEG_DONE]                      = i_autoneg_done; // R12
        rdata_d[pim_pkg::SPC_CODER_EN]                       = coder_q;
        rdata_d[pim_pkg::SPC_SPEED_HI:pim_pkg::SPC_SPEED_LO] = i_resolved_speed_duplex; // R14
      end
      pim_pkg::REG_MMD_CTRL: begin
        rdata_d = mmd_ctrl_q;
      end
      pim_pkg::REG_MMD_DATA: begin
        if (mmd_fn == pim_pkg::PIM_FN_ADDR) begin
          rdata_d = mmd_addr_q;
        end else if (dev_supported(o_ext_device_number)) begin
          rdata_d = i_ext_rdata; // R16 R20
        end
      end
      default: begin
        rdata_d = pim_pkg::WORD_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mgmt_rdata  <= pim_pkg::WORD_ZERO;
      o_mgmt_rvalid <= 1'b0;
    end else begin
      o_mgmt_rvalid <= i_mgmt_rd;
      if (i_mgmt_rd) begin
        o_mgmt_rdata <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  sequence s_src_read;
    i_mgmt_rd && i_mgmt_addr == pim_pkg::REG_IRQ_SRC;
  endsequence

  sequence s_data_write;
    i_mgmt_wr && i_mgmt_addr == pim_pkg::REG_MMD_DATA && mmd_fn != pim_pkg::PIM_FN_ADDR;
  endsequence

  wake_flag_set_a: assert property (i_wake_event |=> flags_q[pim_pkg::FLAG_WAKE]) // R1
    else $error("wake event not latched");
  energy_flag_a: assert property ($rose(i_line_energy_detected) |=> // R2
    flags_q[pim_pkg::FLAG_ENERGY]) else $error("energy flag not latched");
  aneg_flag_a: assert property ($rose(i_autoneg_done) |=> // R3
    flags_q[pim_pkg::FLAG_ANEG_DONE]) else $error("autoneg flag not latched");
  link_down_a: assert property ($fell(i_link_up) |=> // R5
    flags_q[pim_pkg::FLAG_LINK_DOWN]) else $error("link down flag not latched");
  flag_hold_a: assert property (flags_q[pim_pkg::FLAG_PAGE_RX] && !src_read |=> // R8
    flags_q[pim_pkg::FLAG_PAGE_RX]) else $error("page flag dropped without read");
  src_reserved_a: assert property (s_src_read |=> o_mgmt_rvalid && // R8
    o_mgmt_rdata[15:9] == 7'h00 && !o_mgmt_rdata[0]) else $error("reserved bits set");
  read_clear_a: assert property (s_src_read ##0 events == '0 |=> flags_q == '0) // R9
    else $error("flags not cleared by read");
  mask_write_a: assert property (i_mgmt_wr && i_mgmt_addr == pim_pkg::REG_IRQ_MASK |=> // R10
    mask_q == $past(i_mgmt_wdata[pim_pkg::FLAG_HI:pim_pkg::FLAG_LO]))
    else $error("mask not written");
  irq_out_a: assert property (##1 o_irq == $past(|(flags_q & mask_q))) // R11
    else $error("irq does not follow enabled flags");
  coder_bypass_a: assert property (i_mgmt_wr && i_mgmt_addr == pim_pkg::REG_SPECIAL && // R13
    !i_mgmt_wdata[pim_pkg::SPC_CODER_EN] && !i_mii_mode |=> $stable(o_coder_enable))
    else $error("coder bypass taken outside MII");
  speed_read_a: assert property (i_mgmt_rd && i_mgmt_addr == pim_pkg::REG_SPECIAL |=> // R14
    o_mgmt_rdata[pim_pkg::SPC_SPEED_HI:pim_pkg::SPC_SPEED_LO] == $past(i_resolved_speed_duplex))
    else $error("speed code wrong");
  ext_write_a: assert property (s_data_write ##0 dev_supported(o_ext_device_number) |=> // R20
    o_ext_wr && o_ext_wdata == $past(i_mgmt_wdata)) else $error("extended write lost");
  ext_unsup_a: assert property (s_data_write ##0 !dev_supported(o_ext_device_number) |=> // R16
    !o_ext_wr) else $error("write to unsupported device");

  sequence s_addr_write;
    i_mgmt_wr && i_mgmt_addr == pim_pkg::REG_MMD_DATA && mmd_fn == pim_pkg::PIM_FN_ADDR;
  endsequence

  sequence s_data_read;
    i_mgmt_rd && i_mgmt_addr == pim_pkg::REG_MMD_DATA && mmd_fn != pim_pkg::PIM_FN_ADDR;
  endsequence

  sequence s_spc_read;
    i_mgmt_rd && i_mgmt_addr == pim_pkg::REG_SPECIAL;
  endsequence

  sequence s_mask_read;
    i_mgmt_rd && i_mgmt_addr == pim_pkg::REG_IRQ_MASK;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Level-sensed flags latch on the edge after their event
  remote_fault_a: assert property (i_remote_fault |=> // R4
    flags_q[pim_pkg::FLAG_REMOTE_FLT]) else $error("remote fault flag not latched");
  partner_ack_a: assert property (i_partner_ack |=> // R6
    flags_q[pim_pkg::FLAG_PARTNER_ACK]) else $error("partner ack flag not latched");
  par_detect_a: assert property (i_parallel_detect_fault |=> // R7
    flags_q[pim_pkg::FLAG_PAR_DET_FLT]) else $error("parallel detect flag not latched");
  page_rx_a: assert property (i_page_received |=> // R8
    flags_q[pim_pkg::FLAG_PAGE_RX]) else $error("page flag not latched");

  ////////////////////////////////////////////////////////////////////////////////
  // Read clear, mask and interrupt
  set_wins_a: assert property (s_src_read ##0 (events != '0) |=> // R9
    flags_q == $past(events)) else $error("event lost against read clear");
  mask_read_a: assert property (s_mask_read |=> // R10
    o_mgmt_rdata[pim_pkg::FLAG_HI:pim_pkg::FLAG_LO] == $past(mask_q) &&
    (o_mgmt_rdata >> (pim_pkg::FLAG_HI + 1)) == '0 && !o_mgmt_rdata[pim_pkg::FLAG_LO - 1])
    else $error("mask read back wrong");
  irq_masked_a: assert property (mask_q == '0 |=> !o_irq) // R10 R11
    else $error("irq raised with all sources masked");

  ////////////////////////////////////////////////////////////////////////////////
  // Special status and extended window
  aneg_status_a: assert property (s_spc_read |=> // R12
    o_mgmt_rdata[pim_pkg::SPC_ANEG_DONE] == $past(i_autoneg_done))
    else $error("autoneg status wrong");
  coder_read_a: assert property (s_spc_read |=> // R13
    o_mgmt_rdata[pim_pkg::SPC_CODER_EN] == $past(o_coder_enable))
    else $error("coder state read back wrong");
  ext_addr_a: assert property (s_addr_write |=> // R18
    o_ext_addr == $past(i_mgmt_wdata)) else $error("extended address not stored");
  ext_read_a: assert property (s_data_read ##0 dev_supported(o_ext_device_number) |=> // R20
    o_mgmt_rdata == $past(i_ext_rdata)) else $error("extended read data wrong");
  unsup_read_a: assert property (s_data_read ##0 !dev_supported(o_ext_device_number) |=> // R16
    o_mgmt_rdata == pim_pkg::WORD_ZERO) else $error("unsupported device read not zero");

endmodule

// *** sim/phy_irq_status_mmd_access_bench.sv ***
/*
  Self-checking bench of the interrupt, special status and extended access registers.
  Assumes the register block and the extended storage model are compiled before it.
*/
`timescale 1ns/1ps
module phy_irq_status_mmd_access_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        rvalid;
  logic [8:1]  ev = 8'h00;
  logic [2:0]  spd = 3'h1;
  logic        mii = 1'b0;
  logic        coder;
  logic        irq;
  logic [4:0]  xdev;
  logic [15:0] xaddr;
  logic        xwr;
  logic [15:0] xwdata;
  logic [15:0] xrdata;
  logic        xwr_seen;
  int          err_count = 0;
  int          compares = 0;
  int          mask;
  int          coder_m;
  int          sup;
  logic [15:0] a;
  logic [15:0] d;
  int          devs [4] = '{3, 7, 30, 5};
  logic [2:0]  codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};

  always #50 clk = ~clk;

  pim_regs dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_mgmt_addr(addr), .i_mgmt_wr(wr),
    .i_mgmt_rd(rd), .i_mgmt_wdata(wdata), .o_mgmt_rdata(rdata), .o_mgmt_rvalid(rvalid),
    .i_wake_event(ev[8]), .i_line_energy_detected(ev[7]), .i_autoneg_done(ev[6]),
    .i_remote_fault(ev[5]), .i_link_up(~ev[4]), .i_partner_ack(ev[3]),
    .i_parallel_detect_fault(ev[2]), .i_page_received(ev[1]),
    .i_resolved_speed_duplex(spd), .i_mii_mode(mii), .o_coder_enable(coder), .o_irq(irq),
    .o_ext_device_number(xdev), .o_ext_addr(xaddr), .o_ext_wr(xwr), .o_ext_wdata(xwdata),
    .i_ext_rdata(xrdata));

  pim_ext_store store_u (.i_clk_sys(clk), .i_rstn(rstn), .i_ext_device_number(xdev),
    .i_ext_addr(xaddr), .i_ext_wr(xwr), .i_ext_wdata(xwdata), .o_ext_rdata(xrdata));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] rv);
    @(negedge clk);
    addr = ra;
    wdata = rv;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    xwr_seen = xwr;
  endtask

  task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
    @(negedge clk);
    addr = ra;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, exp);
  endtask

  // Expected special register from the model state
  function automatic logic [15:0] spc_exp();
    return {3'h0, ev[6], 5'h00, coder_m[0], 1'b0, spd, 2'h0};
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    err_count++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h851506a4));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    coder_m = 1;
    chk({15'h0000, coder}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0000);
    rd_reg(pim_pkg::REG_IRQ_MASK, 16'h0000);
    rd_reg(5'h05, 16'h0000);
    mask = $urandom;
    wr_reg(pim_pkg::REG_IRQ_MASK, mask[15:0]);
    mask = mask & 16'h01FE;
    rd_reg(pim_pkg::REG_IRQ_MASK, mask[15:0]);
    for (int i = 1; i <= 8; i++) begin
      @(negedge clk);
      ev[i] = 1'b1;
      @(negedge clk);
      ev[i] = 1'b0;
      @(posedge clk);
      #1;
      chk({15'h0000, irq}, {15'h0000, mask[i]});
      rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0001 << i);
      @(posedge clk);
      #1;
      chk({15'h0000, irq}, 16'h0000);
      rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0000);
    end
    @(negedge clk);
    ev[5] = 1'b1;
    rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0020);
    ev[5] = 1'b0;
    rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0020);
    rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0000);
    @(negedge clk);
    ev[6] = 1'b1;
    rd_reg(pim_pkg::REG_SPECIAL, spc_exp());
    ev[6] = 1'b0;
    rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0040);
    rd_reg(pim_pkg::REG_SPECIAL, spc_exp());
    foreach (codes[k]) begin
      spd = codes[k];
      rd_reg(pim_pkg::REG_SPECIAL, spc_exp());
    end
    for (int m = 0; m < 2; m++) begin
      mii = m[0];
      wr_reg(pim_pkg::REG_SPECIAL, 16'h0000);
      coder_m = (m == 1) ? 0 : 1;
      rd_reg(pim_pkg::REG_SPECIAL, spc_exp());
      chk({15'h0000, coder}, coder_m[15:0]);
    end
    wr_reg(pim_pkg::REG_SPECIAL, 16'h0040);
    coder_m = 1;
    rd_reg(pim_pkg::REG_SPECIAL, spc_exp());
    foreach (devs[k]) begin
      a = $urandom;
      d = $urandom;
      sup = (devs[k] != 5);
      wr_reg(pim_pkg::REG_MMD_CTRL, 16'(devs[k]));
      wr_reg(pim_pkg::REG_MMD_DATA, a);
      chk(xaddr, a);
      rd_reg(pim_pkg::REG_MMD_DATA, a);
      wr_reg(pim_pkg::REG_MMD_CTRL, 16'h4000 | 16'(devs[k]));
      chk({11'h000, xdev}, 16'(devs[k]));
      rd_reg(pim_pkg::REG_MMD_CTRL, 16'h4000 | 16'(devs[k]));
      wr_reg(pim_pkg::REG_MMD_DATA, d);
      chk({15'h0000, xwr_seen}, sup[15:0]);
      rd_reg(pim_pkg::REG_MMD_DATA, (sup != 0) ? d : 16'h0000);
    end
    // Mid-run reset with a flag set and the coder bypassed
    wr_reg(pim_pkg::REG_SPECIAL, 16'h0000);
    chk({15'h0000, coder}, 16'h0000);
    @(negedge clk);
    ev[1] = 1'b1;
    @(negedge clk);
    ev[1] = 1'b0;
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk({15'h0000, coder}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    chk({11'h000, xdev}, 16'h0000);
    rd_reg(pim_pkg::REG_IRQ_SRC, 16'h0000);
    rd_reg(pim_pkg::REG_IRQ_MASK, 16'h0000);
    rd_reg(pim_pkg::REG_MMD_CTRL, 16'h0000);
    wrap_up();
  end
endmodule

// *** sim/pim_ext_store.sv ***
/*
  Model of the extended register storage behind the indirect access window.
  Assumes one write pulse per stored word and a combinational read path.
*/
`timescale 1ns/1ps
module pim_ext_store (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // Access from the register block
  input  wire logic [4:0]  i_ext_device_number,
  input  wire logic [15:0] i_ext_addr,
  input  wire logic        i_ext_wr,
  input  wire logic [15:0] i_ext_wdata,
  output logic      [15:0] o_ext_rdata
);
  logic [15:0] mem_q [int];
  int          wr_cnt_q = 0;

  always @(posedge i_clk_sys) begin
    if (i_rstn && i_ext_wr) begin
      mem_q[{i_ext_device_number, i_ext_addr}] = i_ext_wdata;
      wr_cnt_q = wr_cnt_q + 1;
    end
  end

  // Unwritten words show the address XORed with A5C3 rather than a fixed zero
  always @(i_ext_device_number or i_ext_addr or wr_cnt_q) begin
    if (mem_q.exists({i_ext_device_number, i_ext_addr})) begin
      o_ext_rdata = mem_q[{i_ext_device_number, i_ext_addr}];
    end else begin
      o_ext_rdata = i_ext_addr ^ 16'hA5C3;
    end
  end
endmodule
